// ### logic/bcdpi_parallel_input.v
// strobed two-digit bcd parallel input port with a wishbone register slave
// assumes one clock; port pins are asynchronous and synchronised here
//
// Operation
// - input only: eight data, strobe, select lines
// - data and control polarity set independently
// - port acts only in transmit mode
// - strobe valid after 3 ms active, debounce idle
// - sample time restarts on any data or select line change
// - accept at sample end, strobe state irrelevant
// - debounce timer starts on strobe release
// - strobe activity during debounce restarts it only
// - debounce expiry re-arms strobe detection
// - effective debounce always longer than sample time
// - select line level gives address or item
// - active strobe level follows control polarity
// - data one level follows data polarity
// - decode d7-d4 tens, d3-d0 units
// - issue address or item request after decode
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "bcdpi_defines.vh"
module bcdpi_parallel_input #(
   parameter TICK_CYCLES = `BCDPI_TICK_CYCLES,  // clocks per millisecond
   parameter ADR_W       = 8                    // wishbone byte address width
)(
   input  wire             clk,
   input  wire             rstn,
   input  wire             wb_cyc_i,
   input  wire             wb_stb_i,
   input  wire             wb_we_i,
   input  wire [ADR_W-1:0] wb_adr_i,
   input  wire [3:0]       wb_sel_i,
   input  wire [31:0]      wb_dat_i,
   output reg  [31:0]      wb_dat_o,
   output reg              wb_ack_o,
   input  wire [7:0]       dataPin,
   input  wire             itemAddrPin,
   input  wire             strobePin,
   output reg              reqAddr,
   output reg              reqItem,
   output reg              reqInvalid,
   output reg  [6:0]       reqValue
);
   // acquisition states
   localparam [1:0] ST_IDLE    = 2'd0;   // waiting for strobe edge
   localparam [1:0] ST_QUAL    = 2'd1;   // measuring strobe width
   localparam [1:0] ST_SAMPLE  = 2'd2;   // lines must hold still
   localparam [1:0] ST_RELWAIT = 2'd3;   // accepted, strobe still active

   // software registers
   reg  [2:0]  ctrl_reg;                 // mode and polarity bits
   reg  [7:0]  sample_reg;               // sample time, ms
   reg  [7:0]  debounce_reg;             // debounce time, 10 ms units
   reg  [2:0]  status_reg;               // sticky address, item, invalid
   reg  [2:0]  status_next;
   reg  [7:0]  lastRaw_reg;              // last accepted data bits
   reg         lastItem_reg;             // last accepted selector
   reg         lastBad_reg;              // last accepted value was not bcd

   // synchronisers
   reg  [7:0]  dataMeta_reg;
   reg  [7:0]  dataSync_reg;
   reg         selMeta_reg;
   reg         selSync_reg;
   reg         strobeMeta_reg;
   reg         strobeSync_reg;
   reg         strobePrev_reg;           // strobe active level, one cycle back

   // acquisition engine
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [7:0]  cntA_reg;                 // ms count for width and sample
   reg  [7:0]  cntA_next;
   reg  [7:0]  snapData_reg;             // data bits under test
   reg  [7:0]  snapData_next;
   reg         snapItem_reg;             // selector under test
   reg         snapItem_next;
   reg         accept;                   // sample time completed
   reg         restartA;                 // realign width/sample tick

   // debounce engine
   reg         debRun_reg;
   reg  [11:0] cntD_reg;                 // ms count for debounce
   wire        tickA;
   wire        tickD;

   // derived levels
   wire        xmitMode = ctrl_reg[`BCDPI_CTRL_XMIT];
   wire        dataPos  = ctrl_reg[`BCDPI_CTRL_DATAPOS];
   wire        ctrlPos  = ctrl_reg[`BCDPI_CTRL_CTRLPOS];
   wire        strobeAct;
   wire        itemLvl;
   wire [7:0]  dataBits;
   wire        lineChange;
   wire        strobeRise;
   wire        strobeFall;
   wire        debKick;
   wire [7:0]  sampleEff;
   wire [7:0]  debUnits;
   wire [11:0] debMs;
   wire [11:0] debEff;
   wire [3:0]  tens;
   wire [3:0]  units;
   wire        badBcd;
   wire [6:0]  decValue;

   // bus decode
   wire        wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wbWr  = wbHit & wb_we_i & wb_sel_i[0];
   reg  [31:0] readMux;

   // two flops on every pin before any logic reads it
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         dataMeta_reg   <= 8'h00;
         dataSync_reg   <= 8'h00;
         selMeta_reg    <= 1'b0;
         selSync_reg    <= 1'b0;
         // idle level under the reset polarity, so no false edge follows reset
         strobeMeta_reg <= 1'b1;
         strobeSync_reg <= 1'b1;
      end
      else
      begin
         dataMeta_reg   <= dataPin;
         dataSync_reg   <= dataMeta_reg;
         selMeta_reg    <= itemAddrPin;
         selSync_reg    <= selMeta_reg;
         strobeMeta_reg <= strobePin;
         strobeSync_reg <= strobeMeta_reg;
      end
   end

   // polarity mapping, data and control handled apart
   assign strobeAct = ctrlPos ? strobeSync_reg : ~strobeSync_reg;
   assign itemLvl   = ctrlPos ? ~selSync_reg : selSync_reg;
   assign dataBits  = dataPos ? dataSync_reg : ~dataSync_reg;

   // edge terms on the active-level strobe
   assign strobeRise = strobeAct & ~strobePrev_reg;
   assign strobeFall = ~strobeAct & strobePrev_reg;
   assign lineChange = (dataBits != snapData_reg) | (itemLvl != snapItem_reg);

   // zero settings clamp to the smallest legal value
   assign sampleEff = (sample_reg == 8'h00) ? 8'h01 : sample_reg;
   assign debUnits  = (debounce_reg == 8'h00) ? 8'h01 : debounce_reg;
   assign debMs     = `BCDPI_DEB_UNIT_MS * {4'h0, debUnits};
   // short debounce is stretched, sample setting is never touched
   assign debEff    = (debMs > {4'h0, sampleEff}) ? debMs
                      : {4'h0, sampleEff} + 12'h001;

   // bcd split and conversion of the held snapshot
   assign tens     = snapData_reg[7:4];
   assign units    = snapData_reg[3:0];
   assign badBcd   = (tens > 4'h9) | (units > 4'h9);
   assign decValue = {3'h0, tens} * 7'h0a + {3'h0, units};

   // width/sample timer and debounce timer each keep their own phase
   bcdpi_ms_tick #(
      .CYCLES  (TICK_CYCLES)
   ) uTickA (
      .clk     (clk),
      .rstn    (rstn),
      .restart (restartA),
      .tick    (tickA)
   );

   bcdpi_ms_tick #(
      .CYCLES  (TICK_CYCLES)
   ) uTickD (
      .clk     (clk),
      .rstn    (rstn),
      .restart (debKick),
      .tick    (tickD)
   );

   // acquisition next state
   always @*
   begin
      state_next    = state_reg;
      cntA_next     = cntA_reg;
      snapData_next = snapData_reg;
      snapItem_next = snapItem_reg;
      accept        = 1'b0;
      restartA      = 1'b0;
      if (!xmitMode)
      begin
         state_next = ST_IDLE;
         cntA_next  = 8'h00;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               // edges during debounce never open a new cycle
               if (strobeRise && !debRun_reg)
               begin
                  state_next = ST_QUAL;
                  cntA_next  = 8'h00;
                  restartA   = 1'b1;
               end
            end
            ST_QUAL:
            begin
               if (!strobeAct)
                  state_next = ST_IDLE;
               else if (tickA)
               begin
                  if (cntA_reg == `BCDPI_STROBE_MIN_MS - 8'h01)
                  begin
                     state_next    = ST_SAMPLE;
                     cntA_next     = 8'h00;
                     snapData_next = dataBits;
                     snapItem_next = itemLvl;
                     restartA      = 1'b1;
                  end
                  else
                     cntA_next = cntA_reg + 8'h01;
               end
            end
            ST_SAMPLE:
            begin
               // noise on any data or select line starts the wait over
               if (lineChange)
               begin
                  snapData_next = dataBits;
                  snapItem_next = itemLvl;
                  cntA_next     = 8'h00;
                  restartA      = 1'b1;
               end
               else if (tickA)
               begin
                  if (cntA_reg == sampleEff - 8'h01)
                  begin
                     // strobe level does not gate acceptance
                     accept     = 1'b1;
                     cntA_next  = 8'h00;
                     state_next = strobeAct ? ST_RELWAIT : ST_IDLE;
                  end
                  else
                     cntA_next = cntA_reg + 8'h01;
               end
            end
            ST_RELWAIT:
            begin
               if (!strobeAct)
                  state_next = ST_IDLE;
            end
            default:
               state_next = ST_IDLE;
         endcase
      end
   end

   // acquisition registers
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         state_reg      <= ST_IDLE;
         cntA_reg       <= 8'h00;
         snapData_reg   <= 8'h00;
         snapItem_reg   <= 1'b0;
         strobePrev_reg <= 1'b0;
      end
      else
      begin
         state_reg      <= state_next;
         cntA_reg       <= cntA_next;
         snapData_reg   <= snapData_next;
         snapItem_reg   <= snapItem_next;
         strobePrev_reg <= strobeAct;
      end
   end

   // release after a strobe, or any edge while running, restarts debounce
   assign debKick = xmitMode &&
                    ((strobeFall && state_reg != ST_IDLE)
                     || (debRun_reg && strobeRise)
                     || (debRun_reg && strobeFall));

   // debounce timer; expiry re-arms the idle state
   always @(posedge clk)
   begin
      if (!rstn || !xmitMode)
      begin
         debRun_reg <= 1'b0;
         cntD_reg   <= 12'h000;
      end
      else if (debKick)
      begin
         debRun_reg <= 1'b1;
         cntD_reg   <= 12'h000;
      end
      else if (debRun_reg && tickD)
      begin
         if (cntD_reg == debEff - 12'h001)
            debRun_reg <= 1'b0;
         cntD_reg <= cntD_reg + 12'h001;
      end
   end

   // request outputs, one-cycle pulses with a held value
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         reqAddr      <= 1'b0;
         reqItem      <= 1'b0;
         reqInvalid   <= 1'b0;
         reqValue     <= 7'h00;
         lastRaw_reg  <= 8'h00;
         lastItem_reg <= 1'b0;
         lastBad_reg  <= 1'b0;
      end
      else
      begin
         reqAddr    <= accept & ~badBcd & ~snapItem_reg;
         reqItem    <= accept & ~badBcd & snapItem_reg;
         reqInvalid <= accept & badBcd;
         if (accept)
         begin
            reqValue     <= badBcd ? 7'h00 : decValue;
            lastRaw_reg  <= snapData_reg;
            lastItem_reg <= snapItem_reg;
            lastBad_reg  <= badBcd;
         end
      end
   end

   // sticky status, write one to clear; a new event beats the clear
   always @*
   begin
      status_next = status_reg;
      if (wbWr && wb_adr_i == `BCDPI_ADR_STATUS)
         status_next = status_next & ~wb_dat_i[2:0];
      status_next = status_next | {reqInvalid, reqItem, reqAddr};
   end

   // register writes; narrow fields live in byte lane 0
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl_reg     <= `BCDPI_CTRL_RST;
         sample_reg   <= `BCDPI_SAMPLE_RST;
         debounce_reg <= `BCDPI_DEBOUNCE_RST;
         status_reg   <= 3'h0;
      end
      else
      begin
         status_reg <= status_next;
         if (wbWr && wb_adr_i == `BCDPI_ADR_CTRL)
            ctrl_reg <= wb_dat_i[2:0];
         if (wbWr && wb_adr_i == `BCDPI_ADR_SAMPLE)
            sample_reg <= wb_dat_i[7:0];
         if (wbWr && wb_adr_i == `BCDPI_ADR_DEBOUNCE)
            debounce_reg <= wb_dat_i[7:0];
      end
   end

   // read mux; unmapped addresses read zero
   always @*
   begin
      readMux = 32'h0000_0000;
      case (wb_adr_i)
         `BCDPI_ADR_CTRL:     readMux = {29'h0, ctrl_reg};
         `BCDPI_ADR_SAMPLE:   readMux = {24'h0, sample_reg};
         `BCDPI_ADR_DEBOUNCE: readMux = {24'h0, debounce_reg};
         `BCDPI_ADR_STATUS:   readMux = {26'h0, state_reg, debRun_reg, status_reg};
         `BCDPI_ADR_RESULT:   readMux = {8'h0, lastRaw_reg, 6'h0, lastBad_reg,
                                         lastItem_reg, 1'b0, reqValue};
         `BCDPI_ADR_EFFTIME:  readMux = {4'h0, debEff, 8'h0, sampleEff};
         default:             readMux = 32'h0000_0000;
      endcase
   end

   // classic single-cycle slave: ack one clock after the request
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wbHit;
         if (wbHit)
            wb_dat_o <= readMux;
      end
   end
endmodule // bcdpi_parallel_input

// ### common/bcdpi_defines.vh
// constants for the strobed bcd parallel input port
// assumes a single 200 MHz clock; included by bare name from the logic files
`ifndef BCDPI_DEFINES_VH
`define BCDPI_DEFINES_VH

// clock rate and millisecond timebase
`define BCDPI_CLK_MHZ          200
`define BCDPI_TICK_US          1000
`define BCDPI_TICK_CYCLES      (`BCDPI_TICK_US * `BCDPI_CLK_MHZ)

// timing figures in milliseconds
`define BCDPI_STROBE_MIN_MS    8'd3
`define BCDPI_DEB_UNIT_MS      12'd10

// register byte offsets
`define BCDPI_ADR_CTRL         8'h00
`define BCDPI_ADR_SAMPLE       8'h04
`define BCDPI_ADR_DEBOUNCE     8'h08
`define BCDPI_ADR_STATUS       8'h0c
`define BCDPI_ADR_RESULT       8'h10
`define BCDPI_ADR_EFFTIME      8'h14

// control register fields
`define BCDPI_CTRL_XMIT        0
`define BCDPI_CTRL_DATAPOS     1
`define BCDPI_CTRL_CTRLPOS     2

// status register fields
`define BCDPI_ST_ADDR          0
`define BCDPI_ST_ITEM          1
`define BCDPI_ST_INVALID       2
`define BCDPI_ST_DEBRUN        3

// reset values
`define BCDPI_CTRL_RST         3'h1
`define BCDPI_SAMPLE_RST       8'h0a
`define BCDPI_DEBOUNCE_RST     8'h05

`endif

// ### logic/bcdpi_ms_tick.v
// restartable divider giving a one-cycle tick every CYCLES clocks
// assumes restart comes from logic on the same clock
`timescale 1ns/1ps
module bcdpi_ms_tick #(
   parameter CYCLES = 200000             // clocks per tick
)(
   input  wire clk,
   input  wire rstn,
   input  wire restart,                  // realign phase, tick counts from here
   output reg  tick                      // one-cycle pulse
);
   localparam CW = $clog2(CYCLES);
   localparam integer  LASTI = CYCLES - 1;    // full-width terminal count
   localparam [CW-1:0] LAST  = LASTI[CW-1:0];

   reg [CW-1:0] count_reg;               // cycles since last tick or restart

   // restart zeroes phase so a timer started now sees whole milliseconds
   always @(posedge clk)
   begin
      if (!rstn || restart)
      begin
         count_reg <= {CW{1'b0}};
         tick      <= 1'b0;
      end
      else if (count_reg == LAST)
      begin
         count_reg <= {CW{1'b0}};
         tick      <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 1'b1;
         tick      <= 1'b0;
      end
   end
endmodule // bcdpi_ms_tick

// ### sim/bcdpi_monitor.sv
// checker for the bcd parallel input port, bound to its top module
// assumes one clock, synchronous active-low reset, shortened tick via parameter
`timescale 1ns/1ps
`include "bcdpi_defines.vh"
module bcdpi_monitor #(
   parameter TICK_CYCLES = 20,             // clocks per millisecond
   parameter ADR_W       = 8               // byte address width
)(
   input wire             clk,
   input wire             rstn,
   input wire             wb_cyc_i,
   input wire             wb_stb_i,
   input wire             wb_we_i,
   input wire [ADR_W-1:0] wb_adr_i,
   input wire [3:0]       wb_sel_i,
   input wire [31:0]      wb_dat_i,
   input wire             wb_ack_o,
   input wire [7:0]       dataPin,
   input wire             itemAddrPin,
   input wire             reqAddr,
   input wire             reqItem,
   input wire             reqInvalid,
   input wire [6:0]       reqValue
);
   wire        reqAny = reqAddr | reqItem | reqInvalid;     // any request pulse
   wire        wrTake = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
   reg         xmitReg;                                     // shadow of mode bit
   reg  [7:0]  sampleReg;                                   // shadow of sample ms
   reg  [8:0]  pinPrev;                                     // lines one cycle ago
   reg  [15:0] stableReg;                                   // cycles lines unchanged
   // zero is read as one ms, as the design does
   wire [31:0] needCnt = (sampleReg == 8'h00 ? 32'h1 : {24'h0, sampleReg}) * TICK_CYCLES;
   // shadow settings follow writes at the taking edge
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         xmitReg   <= 1'b1;
         sampleReg <= `BCDPI_SAMPLE_RST;
      end
      else if (wrTake && wb_adr_i[7:0] == `BCDPI_ADR_CTRL)
         xmitReg <= wb_dat_i[0];
      else if (wrTake && wb_adr_i[7:0] == `BCDPI_ADR_SAMPLE)
         sampleReg <= wb_dat_i[7:0];
   end
   // stability counter, saturating so long idle never wraps
   always @(posedge clk)
   begin
      pinPrev <= {itemAddrPin, dataPin};
      if (!rstn || pinPrev != {itemAddrPin, dataPin})
         stableReg <= 16'h0000;
      else if (stableReg != 16'hffff)
         stableReg <= stableReg + 16'h0001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_ACK_NEXT:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   AST_ACK_ONE:
   assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   AST_REQ_ONEHOT:
   assert property ($onehot0({reqAddr, reqItem, reqInvalid})) else $error("two requests at once");
   AST_REQ_PULSE:
   assert property (reqAny |=> !reqAny) else $error("request pulse too long");
   AST_VALUE_BCD:
   assert property (reqAddr || reqItem |-> reqValue <= 7'h63) else $error("value above 99");
   AST_INVALID_ZERO:
   assert property (reqInvalid |-> reqValue == 7'h00) else $error("invalid value not zero");
   AST_VALUE_HOLD:
   assert property (!reqAny |=> reqAny || $stable(reqValue)) else $error("value moved");
   AST_MODE_OFF:
   assert property (!xmitReg [*4] |-> !reqAny) else $error("request outside transmit mode");
   AST_LINES_STABLE:
   assert property (reqAny |-> {16'h0000, stableReg} >= needCnt)
      else $error("request before lines stable one sample time");
endmodule // bcdpi_monitor

bind bcdpi_parallel_input bcdpi_monitor #(.TICK_CYCLES(TICK_CYCLES), .ADR_W(ADR_W))
   bcdpi_monitor_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .dataPin(dataPin), .itemAddrPin(itemAddrPin), .reqAddr(reqAddr),
   .reqItem(reqItem), .reqInvalid(reqInvalid), .reqValue(reqValue));

// ### sim/bcdpi_switch_model.sv
// model of a bcd switch or controller driving the port lines
// assumes the bench gives logical values; pins always driven, never released
`timescale 1ns/1ps
module bcdpi_switch_model (
   input  wire       dataPos,              // data lines positive logic
   input  wire       ctrlPos,              // control lines positive logic
   input  wire [7:0] digits,               // logical bcd digits
   input  wire       isItem,               // item number, else address
   input  wire       strobeOn,             // strobe asserted
   output wire [7:0] dataPin,
   output wire       itemAddrPin,
   output wire       strobePin
);
   // a one is high only in positive data logic
   assign dataPin     = dataPos ? digits : ~digits;
   // negative control: address low, item high
   assign itemAddrPin = ctrlPos ? ~isItem : isItem;
   // strobe active low in negative control logic
   assign strobePin   = ctrlPos ? strobeOn : ~strobeOn;
endmodule // bcdpi_switch_model

// ### sim/bcdpi_parallel_input_tb.sv
// self-checking bench for the bcd parallel input port
// assumes a 20-clock millisecond tick; the switch model drives the pins
`timescale 1ns/1ps
`include "bcdpi_defines.vh"
module bcdpi_parallel_input_tb;
   localparam int T = 20;                  // clocks per millisecond
   localparam [63:0] TBL = 64'h6308_10a5_9a47_9900; // digit patterns
   reg         clk = 1'b0;
   reg         rstn, cyc, stb, we;
   reg  [7:0]  adr;
   reg  [3:0]  sel;
   reg  [31:0] wdat, q;                    // write data, last read
   wire [31:0] rdat;
   wire        ack, reqAddr, reqItem, reqInvalid, itemAddrPin, strobePin;
   wire [6:0]  reqValue;
   wire [7:0]  dataPin;
   reg         dPos, cPos, lineItem, strobeAct;
   reg  [7:0]  lineVal;
   reg  [2:0]  gotKind;                    // {invalid, item, addr}
   reg  [6:0]  gotVal;
   int         n_fail = 0, checks = 0, cycles = 0, nReq = 0;
   int         base, start, i, n;
   bcdpi_parallel_input #(.TICK_CYCLES(T)) bcdpi_parallel_input_inst (
      .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .dataPin(dataPin), .itemAddrPin(itemAddrPin), .strobePin(strobePin),
      .reqAddr(reqAddr), .reqItem(reqItem), .reqInvalid(reqInvalid), .reqValue(reqValue));
   bcdpi_switch_model bcdpi_switch_model_inst (.dataPos(dPos), .ctrlPos(cPos),
      .digits(lineVal), .isItem(lineItem), .strobeOn(strobeAct), .dataPin(dataPin),
      .itemAddrPin(itemAddrPin), .strobePin(strobePin));
   always #2.5 clk = ~clk;
   // capture request pulses, cut a hang short
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (reqAddr | reqItem | reqInvalid)
      begin
         nReq    <= nReq + 1;
         gotKind <= {reqInvalid, reqItem, reqAddr};
         gotVal  <= reqValue;
      end
      if (cycles == 20000)
      begin
         n_fail++;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task ms(input int k);
      repeat (k * T) @(posedge clk);
   endtask
   // one classic cycle; waits for ack, then one idle cycle
   task wb(input [7:0] a, input w, input [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hf;
      n = 0;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   // polarity and lines, then wait out any debounce the change caused
   task setup(input [2:0] ctl, input [7:0] v, input it);
      wb(`BCDPI_ADR_CTRL, 1'b1, {29'h0, ctl});
      dPos     <= ctl[1];
      cPos     <= ctl[2];
      lineVal  <= v;
      lineItem <= it;
      ms(12);
      wb(`BCDPI_ADR_STATUS, 1'b1, 32'h7);
      base = nReq;
   endtask
   task waitReq;
      for (n = 0; n < 8 * T && nReq == base; n++)
         @(posedge clk);
   endtask
   task t_regs;
      wb(`BCDPI_ADR_CTRL, 1'b0, 32'h0);
      check(q, 32'h1);
      wb(`BCDPI_ADR_DEBOUNCE, 1'b0, 32'h0);
      check(q, 32'h5);
      wb(`BCDPI_ADR_EFFTIME, 1'b0, 32'h0);
      check(q, 32'h0032000a);
      wb(8'h20, 1'b1, 32'hffffffff);
      wb(8'h20, 1'b0, 32'h0);
      check(q, 32'h0);
      wb(`BCDPI_ADR_SAMPLE, 1'b1, 32'h1e);
      wb(`BCDPI_ADR_DEBOUNCE, 1'b1, 32'h1);
      wb(`BCDPI_ADR_EFFTIME, 1'b0, 32'h0);
      check(q, 32'h001f001e);
      wb(`BCDPI_ADR_SAMPLE, 1'b1, 32'h2);
   endtask
   // strobe held 3 ms or more; early release still accepted
   task t_acq(input [2:0] ctl, input [7:0] v, input it, input int hold);
      reg inv;
      int val;
      inv = v[7:4] > 4'h9 || v[3:0] > 4'h9;
      val = inv ? 0 : v[7:4] * 10 + v[3:0];
      setup(ctl, v, it);
      strobeAct <= 1'b1;
      ms(hold);
      strobeAct <= 1'b0;
      waitReq;
      check(nReq - base, 1);
      check(gotKind, inv ? 3'b100 : {1'b0, it, ~it});
      check(gotVal, val);
      wb(`BCDPI_ADR_STATUS, 1'b0, 32'h0);
      check(q[2:0], inv ? 3'b100 : {1'b0, it, ~it});
      wb(`BCDPI_ADR_RESULT, 1'b0, 32'h0);
      check(q, {8'h0, v, 6'h0, inv, it, 1'b0, val[6:0]});
      ms(12);
   endtask
   task t_short;
      setup(3'h1, 8'h42, 1'b0);
      strobeAct <= 1'b1;
      ms(2);
      strobeAct <= 1'b0;
      ms(8);
      check(nReq - base, 0);
      ms(12);
   endtask
   task t_line;
      wb(`BCDPI_ADR_SAMPLE, 1'b1, 32'h5);
      setup(3'h1, 8'h12, 1'b0);
      strobeAct <= 1'b1;
      ms(5);
      lineVal <= 8'h21;
      start = cycles;
      waitReq;
      check(cycles - start >= 5 * T, 1);
      check(gotVal, 21);
      strobeAct <= 1'b0;
      ms(12);
      wb(`BCDPI_ADR_SAMPLE, 1'b1, 32'h2);
   endtask
   // activity in debounce restarts it; after expiry a strobe works again
   task t_deb;
      setup(3'h1, 8'h05, 1'b0);
      strobeAct <= 1'b1;
      ms(6);
      strobeAct <= 1'b0;
      base = nReq;
      ms(5);
      strobeAct <= 1'b1;
      ms(1);
      strobeAct <= 1'b0;
      ms(6);
      strobeAct <= 1'b1;
      ms(4);
      strobeAct <= 1'b0;
      ms(6);
      check(nReq - base, 0);
      ms(6);
      strobeAct <= 1'b1;
      ms(6);
      check(nReq - base, 1);
      strobeAct <= 1'b0;
      ms(12);
   endtask
   task t_mode;
      setup(3'h0, 8'h33, 1'b0);
      strobeAct <= 1'b1;
      ms(8);
      strobeAct <= 1'b0;
      check(nReq - base, 0);
      setup(3'h1, 8'h33, 1'b0);
   endtask
   initial
   begin
      {rstn, cyc, stb, we, adr, sel, wdat} = 0;
      {dPos, cPos, lineItem, strobeAct, lineVal} = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs;
      for (i = 0; i < 8; i++)
         t_acq({i[2], i[1], 1'b1}, TBL[i * 8 +: 8], i[0], i == 5 ? 4 : 8);
      t_short;
      t_line;
      t_deb;
      t_mode;
      close_out;
   end
endmodule // bcdpi_parallel_input_tb
